// [logic/pes_err_bit.sv]
// one sticky error status bit, write one to clear
// assumes set and clear arrive as single cycle strobes on clk
`timescale 1ns/100ps

module pes_err_bit (
  input  wire logic clk,
  input  wire logic srst,
  input  wire logic set_evt,
  input  wire logic clr_req,
  output logic      flag
);

  logic flag_ff;

  // an event in the clearing cycle keeps the bit set
  always_ff @(posedge clk) begin
    if (srst) begin
      flag_ff <= 1'b0;                        // [RULE_20]
    end else if (set_evt) begin
      flag_ff <= 1'b1;
    end else if (clr_req) begin
      flag_ff <= 1'b0;                        // [RULE_20]
    end
  end

  assign flag = flag_ff;

endmodule

// [logic/pes_pkg.sv]
// constants for the root port error status and link capabilities registers
// assumes dword aligned configuration accesses with byte enables
//
// Notes on behaviour
// [RULE_01] unsupported request received sets status bit 3.
// [RULE_02] unsupported request also sets fatal or non-fatal bit per severity.
// [RULE_03] any fatal error sets status bit 2.
// [RULE_04] any non-fatal error sets status bit 1.
// [RULE_05] any correctable error sets status bit 0.
// [RULE_06] status bits set regardless of device control reporting enables.
// [RULE_07] fatal and non-fatal bits set even for masked uncorrectable errors.
// [RULE_08] correctable bit set even for masked correctable errors.
// [RULE_09] port number 02h read-only in bits 31:24 of link capabilities.
// [RULE_10] l1 exit latency bits 17:15 write-once, reset 010b.
// [RULE_11] software writes both bytes holding l1 exit latency together.
// [RULE_12] firmware sets l1 exit latency at setup if default unsuitable.
// [RULE_13] l0s exit latency read-only bits 14:12, reset 100b.
// [RULE_14] l0s exit latency reported follows common clock configuration bit.
// [RULE_15] aspm support bits 11:10 write-once, reset 11b.
// [RULE_16] maximum lane count 10h read-only in bits 9:4.
// [RULE_17] maximum link speed bits 3:0 hardwired to 1h, 2.5 Gb/s.
// [RULE_18] common clock bit set means shared reference clock, clear means async.
// [RULE_19] fatal errors reported internally when enabled; no message on link.
// [RULE_20] status bits reset to zero, cleared by writing one, zero no effect.
// [RULE_21] write-once field takes first write after reset, ignores later ones.

package pes_pkg;

  // byte addresses of the dword configuration registers
  localparam logic [11:0] OFF_DEV_CTRL_STS = 12'h0a8;
  localparam logic [11:0] OFF_LINK_CAP     = 12'h0ac;
  localparam logic [11:0] OFF_LINK_CTRL    = 12'h0b0;

  // device control fields (low half of the dword)
  localparam int POS_CORR_REP_EN   = 0;
  localparam int POS_NONFATAL_EN   = 1;
  localparam int POS_FATAL_EN      = 2;
  localparam int POS_UR_REP_EN     = 3;
  localparam int POS_MAX_PAYLOAD   = 5;
  localparam int W_MAX_PAYLOAD     = 3;

  // device error status sits in the upper half of the dword
  localparam int POS_STS_BASE      = 16;
  localparam int POS_STS_TX_PEND   = 21;
  localparam int N_ERR_BITS        = 4;
  localparam int ERR_CORR          = 0;
  localparam int ERR_NONFATAL      = 1;
  localparam int ERR_FATAL         = 2;
  localparam int ERR_UNSUPP        = 3;

  // link capabilities fields
  localparam int POS_MAX_SPEED     = 0;
  localparam int W_MAX_SPEED       = 4;
  localparam int POS_MAX_LANES     = 4;
  localparam int W_MAX_LANES       = 6;
  localparam int POS_ASPM_SUP      = 10;
  localparam int W_ASPM_SUP        = 2;
  localparam int POS_L0S_LAT       = 12;
  localparam int W_L0S_LAT         = 3;
  localparam int POS_L1_LAT        = 15;
  localparam int W_L1_LAT          = 3;
  localparam int POS_PORT_NUM      = 24;
  localparam int W_PORT_NUM        = 8;

  localparam logic [3:0] MAX_SPEED_VAL     = 4'h1;
  localparam logic [5:0] MAX_LANES_VAL     = 6'h10;
  localparam logic [1:0] ASPM_SUP_RST      = 2'h3;
  localparam logic [2:0] L0S_LAT_COMMON    = 3'h4;
  localparam logic [2:0] L0S_LAT_ASYNC     = 3'h6;
  localparam logic [2:0] L1_LAT_RST        = 3'h2;
  localparam logic [7:0] PORT_NUM_VAL      = 8'h02;
  localparam logic [31:0] LINK_CAP_RST     = 32'h0201_4d01;

  // link control fields
  localparam int POS_ASPM_CTRL     = 0;
  localparam int W_ASPM_CTRL       = 2;
  localparam int POS_FAR_LOOP      = 2;
  localparam int POS_LINK_DIS      = 4;
  localparam int POS_RETRAIN       = 5;
  localparam int POS_COMMON_CLK    = 6;
  localparam int POS_EXT_SYNCH     = 7;
  localparam logic COMMON_CLK_RST  = 1'b1;

endpackage

// [logic/pes_port_regs.sv]
// root port device control/status, link capabilities and link control
// assumes one configuration request per cycle, dword addressed, from the
// configuration decoder; error events are single cycle strobes from the
// transaction and link layers, taken before any advanced error masking
`timescale 1ns/100ps

module pes_port_regs (
  input  wire logic        clk,
  input  wire logic        srst,
  // configuration access port
  input  wire logic        cfg_req,
  input  wire logic        cfg_wr,
  input  wire logic [11:0] cfg_addr,
  input  wire logic [3:0]  cfg_be,
  input  wire logic [31:0] cfg_wdata,
  output logic             cfg_ack,
  output logic      [31:0] cfg_rdata,
  // error events from the port logic
  input  wire logic        ur_event,
  input  wire logic        fatal_event,
  input  wire logic        nonfatal_event,
  input  wire logic        corr_event,
  input  wire logic        ur_severity_fatal,
  input  wire logic        tx_pending,
  // internal error reports to the root error logic
  output logic             fatal_report,
  output logic             nonfatal_report,
  output logic             corr_report,
  // settings seen by the link logic
  output logic      [2:0]  max_payload,
  output logic      [2:0]  l1_exit_latency,
  output logic      [2:0]  l0s_exit_latency,
  output logic      [1:0]  aspm_support,
  output logic      [1:0]  aspm_ctrl,
  output logic             common_clock_config,
  output logic             link_disable,
  output logic             ext_synch,
  output logic             far_loopback,
  output logic             retrain_req
);

  // ------------------------------------------------------------------
  // address decode
  // ------------------------------------------------------------------
  logic dw_dev;
  logic dw_cap;
  logic dw_link_control_reg;
  logic wr_dev;
  logic wr_cap;
  logic wr_link_control_reg;

  // word select, low two address bits ignored
  always_comb begin
    dw_dev  = (cfg_addr[11:2] == pes_pkg::OFF_DEV_CTRL_STS[11:2]);
    dw_cap  = (cfg_addr[11:2] == pes_pkg::OFF_LINK_CAP[11:2]);
    dw_link_control_reg = (cfg_addr[11:2] == pes_pkg::OFF_LINK_CTRL[11:2]);
  end

  // write strobes per register word
  assign wr_dev  = cfg_req && cfg_wr && dw_dev;
  assign wr_cap  = cfg_req && cfg_wr && dw_cap;
  assign wr_link_control_reg = cfg_req && cfg_wr && dw_link_control_reg;

  // ------------------------------------------------------------------
  // device control
  // ------------------------------------------------------------------
  logic       corr_rep_en_ff;
  logic       nonfatal_en_ff;
  logic       fatal_en_ff;
  logic       ur_rep_en_ff;
  logic [2:0] max_payload_ff;

  // low byte holds the reporting enables and payload size
  always_ff @(posedge clk) begin
    if (srst) begin
      corr_rep_en_ff <= 1'b0;
      nonfatal_en_ff <= 1'b0;
      fatal_en_ff    <= 1'b0;
      ur_rep_en_ff   <= 1'b0;
      max_payload_ff <= 3'h0;
    end else if (wr_dev && cfg_be[0]) begin
      corr_rep_en_ff <= cfg_wdata[pes_pkg::POS_CORR_REP_EN];
      nonfatal_en_ff <= cfg_wdata[pes_pkg::POS_NONFATAL_EN];
      fatal_en_ff    <= cfg_wdata[pes_pkg::POS_FATAL_EN];
      ur_rep_en_ff   <= cfg_wdata[pes_pkg::POS_UR_REP_EN];
      max_payload_ff <= cfg_wdata[pes_pkg::POS_MAX_PAYLOAD +:
                                  pes_pkg::W_MAX_PAYLOAD];
    end
  end

  // ------------------------------------------------------------------
  // device error status
  // ------------------------------------------------------------------
  logic [3:0] err_set;
  logic [3:0] err_clr;
  logic [3:0] err_flags;

  // sources are unmasked events, so enables and masks never gate them
  always_comb begin
    err_set = 4'h0;
    err_set[pes_pkg::ERR_UNSUPP]   = ur_event;                 // [RULE_01]
    err_set[pes_pkg::ERR_FATAL]    = fatal_event               // [RULE_03]
                                   | (ur_event &
                                      ur_severity_fatal);      // [RULE_02]
    err_set[pes_pkg::ERR_NONFATAL] = nonfatal_event            // [RULE_04]
                                   | (ur_event &
                                      ~ur_severity_fatal);     // [RULE_02]
    err_set[pes_pkg::ERR_CORR]     = corr_event;               // [RULE_05]
  end
  // the status bits ignore the reporting enables entirely [RULE_06]
  // masked uncorrectable errors still reach the fatal/non-fatal bits [RULE_07]
  // masked correctable errors still reach the correctable bit [RULE_08]

  // one cell per status bit, cleared by writing one in byte lane 2
  genvar gi;
  generate
    for (gi = 0; gi < pes_pkg::N_ERR_BITS; gi++) begin : g_err
      assign err_clr[gi] = wr_dev && cfg_be[2] &&
                           cfg_wdata[pes_pkg::POS_STS_BASE + gi]; // [RULE_20]
      pes_err_bit u_err (
        .clk     (clk),
        .srst    (srst),
        .set_evt (err_set[gi]),
        .clr_req (err_clr[gi]),
        .flag    (err_flags[gi])
      );
    end
  endgenerate

  // ------------------------------------------------------------------
  // internal error reporting
  // ------------------------------------------------------------------
  logic fatal_report_ff;
  logic nonfatal_report_ff;
  logic corr_report_ff;
  logic nxt_fatal_report;
  logic nxt_nonfatal_report;
  logic nxt_corr_report;

  // reports stay inside the root, nothing is sent on the link
  always_comb begin
    nxt_fatal_report    = (fatal_event & fatal_en_ff)          // [RULE_19]
                        | (ur_event & ur_rep_en_ff &
                           ur_severity_fatal & fatal_en_ff);
    nxt_nonfatal_report = (nonfatal_event & nonfatal_en_ff)
                        | (ur_event & ur_rep_en_ff &
                           ~ur_severity_fatal & nonfatal_en_ff);
    nxt_corr_report     = corr_event & corr_rep_en_ff;
  end

  // one cycle report pulses
  always_ff @(posedge clk) begin
    if (srst) begin
      fatal_report_ff    <= 1'b0;
      nonfatal_report_ff <= 1'b0;
      corr_report_ff     <= 1'b0;
    end else begin
      fatal_report_ff    <= nxt_fatal_report;                  // [RULE_19]
      nonfatal_report_ff <= nxt_nonfatal_report;
      corr_report_ff     <= nxt_corr_report;
    end
  end

  // ------------------------------------------------------------------
  // link capabilities write-once fields
  // ------------------------------------------------------------------
  logic [2:0] l1_bit_en;
  logic [1:0] aspm_bit_en;
  logic [2:0] l1_lat;
  logic [1:0] aspm_sup;

  // bit 15 lives in lane 1, bits 17:16 in lane 2
  assign l1_bit_en   = {cfg_be[2], cfg_be[2], cfg_be[1]};
  assign aspm_bit_en = {cfg_be[1], cfg_be[1]};

  // any write touching a lane of the field consumes its single write;
  // software is expected to write both lanes at once [RULE_11]
  // the default stays unless firmware rewrites it at setup [RULE_12]
  pes_wonce #(
    .W   (pes_pkg::W_L1_LAT),
    .RST (pes_pkg::L1_LAT_RST)
  ) u_l1_lat (
    .clk    (clk),
    .srst   (srst),
    .wr_en  (wr_cap && (cfg_be[1] || cfg_be[2])),              // [RULE_10]
    .bit_en (l1_bit_en),
    .wdata  (cfg_wdata[pes_pkg::POS_L1_LAT +: pes_pkg::W_L1_LAT]),
    .value  (l1_lat)
  );

  // power management support, entirely in lane 1
  pes_wonce #(
    .W   (pes_pkg::W_ASPM_SUP),
    .RST (pes_pkg::ASPM_SUP_RST)
  ) u_aspm_sup (
    .clk    (clk),
    .srst   (srst),
    .wr_en  (wr_cap && cfg_be[1]),                             // [RULE_15]
    .bit_en (aspm_bit_en),
    .wdata  (cfg_wdata[pes_pkg::POS_ASPM_SUP +: pes_pkg::W_ASPM_SUP]),
    .value  (aspm_sup)
  );

  // ------------------------------------------------------------------
  // link control
  // ------------------------------------------------------------------
  logic [1:0] aspm_ctrl_ff;
  logic       far_loop_ff;
  logic       link_dis_ff;
  logic       common_clk_ff;
  logic       ext_synch_ff;
  logic       retrain_ff;

  // low byte holds every writable control bit
  always_ff @(posedge clk) begin
    if (srst) begin
      aspm_ctrl_ff  <= 2'h0;
      far_loop_ff   <= 1'b0;
      link_dis_ff   <= 1'b0;
      common_clk_ff <= pes_pkg::COMMON_CLK_RST;
      ext_synch_ff  <= 1'b0;
    end else if (wr_link_control_reg && cfg_be[0]) begin
      aspm_ctrl_ff  <= cfg_wdata[pes_pkg::POS_ASPM_CTRL +:
                                 pes_pkg::W_ASPM_CTRL];
      far_loop_ff   <= cfg_wdata[pes_pkg::POS_FAR_LOOP];
      link_dis_ff   <= cfg_wdata[pes_pkg::POS_LINK_DIS];
      // 1 means shared reference clock, 0 asynchronous clocks
      common_clk_ff <= cfg_wdata[pes_pkg::POS_COMMON_CLK];     // [RULE_18]
      ext_synch_ff  <= cfg_wdata[pes_pkg::POS_EXT_SYNCH];
    end
  end

  // retrain is a self clearing strobe, it never reads back as one
  always_ff @(posedge clk) begin
    if (srst) begin
      retrain_ff <= 1'b0;
    end else begin
      retrain_ff <= wr_link_control_reg && cfg_be[0] &&
                    cfg_wdata[pes_pkg::POS_RETRAIN];
    end
  end

  // ------------------------------------------------------------------
  // l0s exit latency selection
  // ------------------------------------------------------------------
  logic [2:0] l0s_lat;

  // shorter exit with a common reference clock
  always_comb begin
    if (common_clk_ff) begin
      l0s_lat = pes_pkg::L0S_LAT_COMMON;                       // [RULE_13]
    end else begin
      l0s_lat = pes_pkg::L0S_LAT_ASYNC;                        // [RULE_14]
    end
  end

  // ------------------------------------------------------------------
  // read data assembly
  // ------------------------------------------------------------------
  logic [31:0] rd_word;

  // unmapped words and reserved bits read as zero
  always_comb begin
    rd_word = 32'h0000_0000;
    case (1'b1)
      dw_dev: begin
        rd_word[pes_pkg::POS_CORR_REP_EN] = corr_rep_en_ff;
        rd_word[pes_pkg::POS_NONFATAL_EN] = nonfatal_en_ff;
        rd_word[pes_pkg::POS_FATAL_EN]    = fatal_en_ff;
        rd_word[pes_pkg::POS_UR_REP_EN]   = ur_rep_en_ff;
        rd_word[pes_pkg::POS_MAX_PAYLOAD +:
                pes_pkg::W_MAX_PAYLOAD]   = max_payload_ff;
        rd_word[pes_pkg::POS_STS_BASE +:
                pes_pkg::N_ERR_BITS]      = err_flags;
        rd_word[pes_pkg::POS_STS_TX_PEND] = tx_pending;
      end
      dw_cap: begin
        rd_word[pes_pkg::POS_MAX_SPEED +:
                pes_pkg::W_MAX_SPEED] = pes_pkg::MAX_SPEED_VAL;   // [RULE_17]
        rd_word[pes_pkg::POS_MAX_LANES +:
                pes_pkg::W_MAX_LANES] = pes_pkg::MAX_LANES_VAL;   // [RULE_16]
        rd_word[pes_pkg::POS_ASPM_SUP +:
                pes_pkg::W_ASPM_SUP]  = aspm_sup;                 // [RULE_15]
        rd_word[pes_pkg::POS_L0S_LAT +:
                pes_pkg::W_L0S_LAT]   = l0s_lat;                  // [RULE_13]
        rd_word[pes_pkg::POS_L1_LAT +:
                pes_pkg::W_L1_LAT]    = l1_lat;                   // [RULE_10]
        rd_word[pes_pkg::POS_PORT_NUM +:
                pes_pkg::W_PORT_NUM]  = pes_pkg::PORT_NUM_VAL;    // [RULE_09]
      end
      dw_link_control_reg: begin
        rd_word[pes_pkg::POS_ASPM_CTRL +:
                pes_pkg::W_ASPM_CTRL]     = aspm_ctrl_ff;
        rd_word[pes_pkg::POS_FAR_LOOP]   = far_loop_ff;
        rd_word[pes_pkg::POS_LINK_DIS]   = link_dis_ff;
        rd_word[pes_pkg::POS_COMMON_CLK] = common_clk_ff;
        rd_word[pes_pkg::POS_EXT_SYNCH]  = ext_synch_ff;
      end
      default: begin
        rd_word = 32'h0000_0000;
      end
    endcase
  end

  // ------------------------------------------------------------------
  // access completion
  // ------------------------------------------------------------------
  logic        cfg_ack_ff;
  logic [31:0] cfg_rdata_ff;

  // every request, mapped or not, completes one cycle later
  always_ff @(posedge clk) begin
    if (srst) begin
      cfg_ack_ff <= 1'b0;
    end else begin
      cfg_ack_ff <= cfg_req;
    end
  end

  // read data captured with a read request, held until the next read
  always_ff @(posedge clk) begin
    if (srst) begin
      cfg_rdata_ff <= 32'h0000_0000;
    end else if (cfg_req && !cfg_wr) begin
      cfg_rdata_ff <= rd_word;
    end
  end

  // ------------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------------
  assign cfg_ack             = cfg_ack_ff;
  assign cfg_rdata           = cfg_rdata_ff;
  assign fatal_report        = fatal_report_ff;
  assign nonfatal_report     = nonfatal_report_ff;
  assign corr_report         = corr_report_ff;
  assign max_payload         = max_payload_ff;
  assign l1_exit_latency     = l1_lat;
  assign l0s_exit_latency    = l0s_lat;
  assign aspm_support        = aspm_sup;
  assign aspm_ctrl           = aspm_ctrl_ff;
  assign common_clock_config = common_clk_ff;
  assign link_disable        = link_dis_ff;
  assign ext_synch           = ext_synch_ff;
  assign far_loopback        = far_loop_ff;
  assign retrain_req         = retrain_ff;

endmodule

// [logic/pes_wonce.sv]
// write-once register field, locked by its first write after reset
// assumes bit_en marks bits whose byte lane is enabled in the write
`timescale 1ns/100ps

module pes_wonce #(
  parameter int         W   = 2,
  parameter logic [W-1:0] RST = '0
) (
  input  wire logic         clk,
  input  wire logic         srst,
  input  wire logic         wr_en,
  input  wire logic [W-1:0] bit_en,
  input  wire logic [W-1:0] wdata,
  output logic      [W-1:0] value
);

  logic [W-1:0] value_ff;
  logic         locked_ff;

  // first touching write loads enabled bits, later ones are dropped
  always_ff @(posedge clk) begin
    if (srst) begin
      value_ff  <= RST;
      locked_ff <= 1'b0;
    end else if (wr_en && !locked_ff) begin
      value_ff  <= (value_ff & ~bit_en) | (wdata & bit_en); // [RULE_21]
      locked_ff <= 1'b1;                                    // [RULE_21]
    end
  end

  assign value = value_ff;

endmodule

// [tb/pes_evt_src.sv]
// error event source standing for the port's transaction and link logic
// assumes fire and kind change away from the rising edge of clk
`timescale 1ns/100ps

module pes_evt_src (
  input  wire logic       clk,
  input  wire logic       fire,
  input  wire logic [1:0] kind,
  output logic      [3:0] evt
);
  // one-cycle pulse per fire: corr, nonfatal, fatal, unsupported
  always_ff @(posedge clk) begin
    evt <= fire ? (4'h1 << kind) : 4'h0;
  end
endmodule

// [tb/pes_port_regs_asserts.sv]
// checker: config access timing, error logging, link capability fields
// assumes it is bound into every port register instance, one clock
`timescale 1ns/100ps

module pes_port_regs_asserts (
  input wire logic        clk,
  input wire logic        srst,
  input wire logic        cfg_req,
  input wire logic        cfg_wr,
  input wire logic [11:0] cfg_addr,
  input wire logic [3:0]  cfg_be,
  input wire logic [31:0] cfg_wdata,
  input wire logic        cfg_ack,
  input wire logic [31:0] cfg_rdata,
  input wire logic        ur_event,
  input wire logic        fatal_event,
  input wire logic        nonfatal_event,
  input wire logic        corr_event,
  input wire logic        ur_severity_fatal,
  input wire logic        fatal_report,
  input wire logic        nonfatal_report,
  input wire logic        corr_report,
  input wire logic [2:0]  l1_exit_latency,
  input wire logic [2:0]  l0s_exit_latency,
  input wire logic [1:0]  aspm_support,
  input wire logic        common_clock_config
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  logic rd_sts, rd_cap, wr_cap, clr_sts, no_evt, l1_lock_ff, aspm_lock_ff;

  // decoded accesses to status and capability dwords
  assign rd_sts = cfg_req && !cfg_wr && cfg_addr[11:2] == 10'h02a;
  assign rd_cap = cfg_req && !cfg_wr && cfg_addr[11:2] == 10'h02b;
  assign wr_cap = cfg_req && cfg_wr && cfg_addr[11:2] == 10'h02b;
  assign clr_sts = cfg_req && cfg_wr && cfg_addr[11:2] == 10'h02a
                   && cfg_be[2] && cfg_wdata[19:16] == 4'hf;
  assign no_evt = !(ur_event || fatal_event || nonfatal_event || corr_event);

  // remembers the locking write of each write-once field
  always_ff @(posedge clk) begin
    if (srst)
      l1_lock_ff <= 1'b0;
    else if (wr_cap && (cfg_be[1] || cfg_be[2]))
      l1_lock_ff <= 1'b1;
  end
  always_ff @(posedge clk) begin
    if (srst)
      aspm_lock_ff <= 1'b0;
    else if (wr_cap && cfg_be[1])
      aspm_lock_ff <= 1'b1;
  end

  sequence ur_then_rd;
    ur_event ##1 rd_sts;
  endsequence
  sequence clr_then_rd;
    clr_sts && no_evt ##1 no_evt ##1 rd_sts;
  endsequence

  ack_one_a: assert property (cfg_ack == $past(cfg_req))
    else $error("ack not one cycle after request");
  cap_read_a: assert property (
    rd_cap |=> cfg_rdata == {8'h02, 6'h00, $past(l1_exit_latency),
      $past(l0s_exit_latency), $past(aspm_support), 6'h10, 4'h1})
    else $error("link capability read wrong");
  l0s_sel_a: assert property (
    l0s_exit_latency == (common_clock_config ?
      pes_pkg::L0S_LAT_COMMON : pes_pkg::L0S_LAT_ASYNC))
    else $error("l0s latency does not follow common clock");
  ur_log_a: assert property (ur_then_rd |=> cfg_rdata[19] &&
    ($past(ur_severity_fatal, 2) ? cfg_rdata[18] : cfg_rdata[17]))
    else $error("unsupported request not logged");
  fatal_log_a: assert property (
    fatal_event ##1 rd_sts |=> cfg_rdata[18])
    else $error("fatal error not logged");
  corr_log_a: assert property (
    corr_event ##1 rd_sts |=> cfg_rdata[16])
    else $error("correctable error not logged");
  sts_clear_a: assert property (
    clr_then_rd |=> cfg_rdata[19:16] == 4'h0)
    else $error("status not cleared by one");
  l1_once_a: assert property ($changed(l1_exit_latency) |->
    $past(wr_cap && (cfg_be[1] || cfg_be[2]) && !l1_lock_ff))
    else $error("l1 latency changed without first write");
  aspm_once_a: assert property ($changed(aspm_support) |->
    $past(wr_cap && cfg_be[1] && !aspm_lock_ff))
    else $error("aspm support changed without first write");
  report_cause_a: assert property (
    (fatal_report |-> $past(fatal_event || ur_event)) and
    (nonfatal_report |-> $past(nonfatal_event || ur_event)) and
    (corr_report |-> $past(corr_event)))
    else $error("report without an event");
endmodule

bind pes_port_regs pes_port_regs_asserts i_chk (
  .clk, .srst, .cfg_req, .cfg_wr, .cfg_addr, .cfg_be, .cfg_wdata,
  .cfg_ack, .cfg_rdata, .ur_event, .fatal_event, .nonfatal_event,
  .corr_event, .ur_severity_fatal, .fatal_report, .nonfatal_report,
  .corr_report, .l1_exit_latency, .l0s_exit_latency, .aspm_support,
  .common_clock_config
);

// [tb/pes_port_regs_bench.sv]
// bench: config reads and writes, error events, write-once fields
// assumes the checker is bound in and the event source model is present
`timescale 1ns/100ps

module pes_port_regs_bench;
  localparam logic [11:0] A_STS = 12'h0a8;
  localparam logic [11:0] A_CAP = 12'h0ac;
  localparam logic [11:0] A_LCT = 12'h0b0;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic        cfg_req = 1'b0;
  logic        cfg_wr = 1'b0;
  logic [11:0] cfg_addr = 12'h000;
  logic [3:0]  cfg_be = 4'h0;
  logic [31:0] cfg_wdata = 32'h0;
  logic        fire = 1'b0;
  logic [1:0]  kind = 2'h0;
  logic        ur_severity_fatal = 1'b0;
  logic        tx_pending = 1'b0;
  logic        cfg_ack, fatal_report, nonfatal_report, corr_report;
  logic        common_clock_config, link_disable, ext_synch, far_loopback;
  logic        retrain_req;
  logic [31:0] cfg_rdata, rd;
  logic [3:0]  evt;
  logic [2:0]  l1_exit_latency, l0s_exit_latency, rep_seen, max_payload;
  logic [1:0]  aspm_support, aspm_ctrl;
  logic [1:0]  ev_kind [5] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h3};
  logic [3:0]  ev_sts [5] = '{4'h1, 4'h2, 4'h4, 4'hc, 4'ha};
  logic [2:0]  ev_rep [5] = '{3'h1, 3'h2, 3'h4, 3'h4, 3'h2};
  int          bad_count = 0;
  int          checks = 0;

  always #10 clk = ~clk;

  pes_port_regs i_dut (
    .clk, .srst, .cfg_req, .cfg_wr, .cfg_addr, .cfg_be, .cfg_wdata,
    .cfg_ack, .cfg_rdata, .ur_event(evt[3]), .fatal_event(evt[2]),
    .nonfatal_event(evt[1]), .corr_event(evt[0]), .ur_severity_fatal,
    .tx_pending, .fatal_report, .nonfatal_report, .corr_report,
    .max_payload, .l1_exit_latency, .l0s_exit_latency, .aspm_support,
    .aspm_ctrl, .common_clock_config, .link_disable, .ext_synch,
    .far_loopback, .retrain_req
  );
  pes_evt_src i_src (.clk, .fire, .kind, .evt);

  // collects report pulses since the last event
  always @(posedge clk) begin
    rep_seen <= fire ? 3'h0
                : rep_seen | {fatal_report, nonfatal_report, corr_report};
  end

  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // one config access, request held for its taking edge
  task automatic access(logic wr, logic [11:0] addr, logic [3:0] be,
                        logic [31:0] wdata);
    @(negedge clk);
    cfg_req = 1'b1;
    cfg_wr = wr;
    cfg_addr = addr;
    cfg_be = be;
    cfg_wdata = wdata;
    @(negedge clk);
    cfg_req = 1'b0;
    check("ack", {31'h0, cfg_ack}, 32'h1);
    rd = cfg_rdata;
  endtask

  task automatic pulse(logic [1:0] k);
    @(negedge clk);
    fire = 1'b1;
    kind = k;
    @(negedge clk);
    fire = 1'b0;
  endtask

  task automatic do_reset();
    srst = 1'b1;
    repeat (20) @(negedge clk);
    srst = 1'b0;
  endtask

  task automatic stop_test();
    if (bad_count == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // watchdog against a hung access
  initial begin
    repeat (5000) @(posedge clk);
    bad_count++;
    stop_test();
  end

  initial begin
    do_reset();
    access(1'b0, A_CAP, 4'h0, 32'h0);
    check("caps", rd, 32'h0201_4d01);
    access(1'b0, A_STS, 4'h0, 32'h0);
    check("sts rst", rd[19:16], 4'h0);
    // every event kind, reporting off then on
    for (int en = 0; en < 2; en++) begin
      access(1'b1, A_STS, 4'h1, en ? 32'h0000_00ef : 32'h0);
      for (int i = 0; i < 5; i++) begin
        ur_severity_fatal = (i == 3);
        pulse(ev_kind[i]);
        access(1'b0, A_STS, 4'h0, 32'h0);
        check("sts", rd[19:16], ev_sts[i]);
        check("rep", rep_seen, en ? ev_rep[i] : 3'h0);
        access(1'b1, A_STS, 4'h4, 32'h0);
        access(1'b0, A_STS, 4'h0, 32'h0);
        check("kept", rd[19:16], ev_sts[i]);
        access(1'b1, A_STS, 4'h4, 32'h000f_0000);
        access(1'b0, A_STS, 4'h0, 32'h0);
        check("clr", rd[19:16], 4'h0);
      end
    end
    // device control read back with pending transactions
    tx_pending = 1'b1;
    access(1'b0, A_STS, 4'h0, 32'h0);
    check("dctl", rd, 32'h0020_00ef);
    check("mps", max_payload, 3'h7);
    // write-once fields take only the first write
    access(1'b1, A_CAP, 4'h6, 32'hfffe_f7ff);
    access(1'b1, A_CAP, 4'hf, 32'h0);
    access(1'b0, A_CAP, 4'h0, 32'h0);
    check("once", rd, 32'h0202_c501);
    check("l1", l1_exit_latency, 3'h5);
    // l0s latency follows common clock configuration
    access(1'b1, A_LCT, 4'h1, 32'h0);
    access(1'b0, A_CAP, 4'h0, 32'h0);
    check("l0s", rd[14:12], pes_pkg::L0S_LAT_ASYNC);
    access(1'b1, A_LCT, 4'h1, 32'h0000_00f7);
    check("retrain", retrain_req, 1'b1);
    access(1'b0, A_CAP, 4'h0, 32'h0);
    check("l0s cc", rd[14:12], 3'h4);
    access(1'b0, A_LCT, 4'h0, 32'h0);
    check("link_control_reg", rd, 32'h0000_00d7);
    check("link_control_reg out", {ext_synch, common_clock_config, link_disable,
          far_loopback, aspm_ctrl}, 6'h3f);
    access(1'b0, 12'h0b4, 4'h0, 32'h0);
    check("unmapped", rd, 32'h0);
    // second reset unlocks the write-once fields
    do_reset();
    access(1'b0, A_CAP, 4'h0, 32'h0);
    check("caps rst", rd, 32'h0201_4d01);
    access(1'b1, A_CAP, 4'h6, 32'h0);
    access(1'b0, A_CAP, 4'h0, 32'h0);
    check("relock", rd, 32'h0200_4101);
    stop_test();
  end
endmodule
